/* File: line_chk_pkg.sv */
// Constants and encodings for the cache-line-size request checker
// Function
// (R1) Line size is a fixed design parameter, never changed at run time.
// (R2) Line size below 16 bytes is rejected at elaboration.
// (R3) Line size at most min(2048, 16 times bus bytes).
// (R4) Twelve coherent request types must each cover exactly one full line.
// (R5) Line-sized requests also obey regular burst shape and alignment limits.
// (R6) Beat count must be 1, 2, 4, 8 or 16.
// (R7) Multi-beat requests use the full bus width per beat.
// (R8) Incrementing bursts start aligned to the line size.
// (R9) Wrapping bursts align to beat size; fixed bursts are forbidden.
// (R10) Most line-sized requests need inner or outer shareable domain.
// (R11) Clean, invalidate and write-evict requests may also be non-shareable.
// (R12) Line-sized requests are normal accesses and modifiable.
// (R13) Lock must be zero for the non-exclusive line-sized requests.
// (R14) Read-clean, read-shared and clean-unique may set lock.
// (R15) Protection and quality-of-service fields are never checked.
// (R16) Line-unique writes and evict writes need every strobe set.
// (R17) Dataless requests still encode a full line in burst length.
// (R18) Check each address handshake; raise a per-channel violation flag.
package line_chk_pkg;
   // Burst types
   localparam logic [1:0] BURST_FIXED = 2'h0;
   localparam logic [1:0] BURST_INCR  = 2'h1;
   localparam logic [1:0] BURST_WRAP  = 2'h2;
   // Domains
   localparam logic [1:0] DOM_NONSH   = 2'h0;
   localparam logic [1:0] DOM_INNER   = 2'h1;
   localparam logic [1:0] DOM_OUTER   = 2'h2;
   // Line size limits in bytes and in beats
   localparam int LINE_MIN_BYTES      = 16;
   localparam int LINE_MAX_BYTES      = 2048;
   localparam int MAX_BEATS           = 16;
   // Cache attribute modifiable bit position
   localparam int CACHE_MOD_BIT       = 1;
   // Read request snoop codes (domain must be shareable to mean these)
   localparam logic [3:0] RD_ONCE_OR_NOSNOOP = 4'h0;
   localparam logic [3:0] RD_SHARED   = 4'h1;
   localparam logic [3:0] RD_CLEAN    = 4'h2;
   localparam logic [3:0] RD_NSD      = 4'h3;
   localparam logic [3:0] RD_UNIQUE   = 4'h7;
   localparam logic [3:0] RD_CLN_UNQ  = 4'hB;
   localparam logic [3:0] RD_MK_UNQ   = 4'hC;
   localparam logic [3:0] RD_CLN_SH   = 4'h8;
   localparam logic [3:0] RD_CLN_INV  = 4'h9;
   localparam logic [3:0] RD_MK_INV   = 4'hD;
   // Write request snoop codes
   localparam logic [2:0] WR_LINE_UNQ = 3'h1;
   localparam logic [2:0] WR_EVICT_NODATA = 3'h4;
   localparam logic [2:0] WR_EVICT_DATA   = 3'h5;
endpackage : line_chk_pkg

/* File: line_shape_chk.sv */
`timescale 1ns/1ps
// Combinational burst shape check for one line-sized request
module line_shape_chk
   import line_chk_pkg::*;
#(
   parameter int BUS_BYTES  = 16,
   parameter int LINE_BYTES = 64,
   parameter int AW         = 32
) (
   input  wire logic [AW-1:0] addr_i,
   input  wire logic [7:0]    len_i,
   input  wire logic [2:0]    size_i,
   input  wire logic [1:0]    burst_i,
   output logic               bad_o
);
   localparam logic [2:0] BUS_SIZE = 3'($clog2(BUS_BYTES));
   localparam int LINE_LOG = $clog2(LINE_BYTES);

   logic [8:0]  beats;
   logic [12:0] total;
   logic        len_ok;
   logic        size_ok;
   logic        align_ok;

   // Beats and byte total; line-sized means total equals line
   always_comb begin
      beats    = 9'(len_i) + 9'h001;
      total    = 13'(beats) << size_i;
      len_ok   = (beats == 9'h001) || (beats == 9'h002) || (beats == 9'h004) ||
                 (beats == 9'h008) || (beats == 9'h010);                 // R6 R5
      size_ok  = (beats == 9'h001) || (size_i == BUS_SIZE);             // R7
      align_ok = 1'b0;
      case (burst_i)
         BURST_INCR: align_ok = (addr_i[LINE_LOG-1:0] == '0);           // R8
         BURST_WRAP: align_ok = ((addr_i & ((AW'(1) << size_i) - AW'(1))) == '0); // R9
         default:    align_ok = 1'b0;                                   // R9 fixed
      endcase
      bad_o = !(len_ok && size_ok && align_ok &&
                (total == 13'(LINE_BYTES)));                            // R4 R17
   end
endmodule : line_shape_chk

/* File: line_txn_checker.sv */
`timescale 1ns/1ps
// Cache-line-size request checker on the read and write address channels
module line_txn_checker
   import line_chk_pkg::*;
#(
   parameter int BUS_BYTES  = 16,
   parameter int LINE_BYTES = 64,   // Fixed at build time
   parameter int AW         = 32
) (
   input  wire logic                   core_clk_i,
   input  wire logic                   resetn_i,
   // Read address channel
   input  wire logic                   arvalid_i,
   input  wire logic                   arready_i,
   input  wire logic [AW-1:0]          araddr_i,
   input  wire logic [7:0]             arlen_i,
   input  wire logic [2:0]             arsize_i,
   input  wire logic [1:0]             arburst_i,
   input  wire logic                   arlock_i,
   input  wire logic [3:0]             arcache_i,
   input  wire logic [2:0]             arprot_i,
   input  wire logic [3:0]             arqos_i,
   input  wire logic [3:0]             arsnoop_i,
   input  wire logic [1:0]             ardomain_i,
   input  wire logic [1:0]             arbar_i,
   // Write address channel
   input  wire logic                   awvalid_i,
   input  wire logic                   awready_i,
   input  wire logic [AW-1:0]          awaddr_i,
   input  wire logic [7:0]             awlen_i,
   input  wire logic [2:0]             awsize_i,
   input  wire logic [1:0]             awburst_i,
   input  wire logic                   awlock_i,
   input  wire logic [3:0]             awcache_i,
   input  wire logic [2:0]             awprot_i,
   input  wire logic [3:0]             awqos_i,
   input  wire logic [2:0]             awsnoop_i,
   input  wire logic [1:0]             awdomain_i,
   input  wire logic [1:0]             awbar_i,
   // Write data channel
   input  wire logic                   wvalid_i,
   input  wire logic                   wready_i,
   input  wire logic [BUS_BYTES-1:0]   wstrb_i,
   input  wire logic                   wlast_i,
   // Violation flags, one cycle after the offending handshake
   output logic                        ar_violation_o,
   output logic                        aw_violation_o,
   output logic                        w_violation_o
);
   // Elaboration-time line size limits
   localparam int MAX_LINE = (LINE_MAX_BYTES < MAX_BEATS * BUS_BYTES) ?
                             LINE_MAX_BYTES : MAX_BEATS * BUS_BYTES;
   if (LINE_BYTES < LINE_MIN_BYTES) begin : g_min
      $error("line size below minimum");                                // R2
   end
   if (LINE_BYTES > MAX_LINE) begin : g_max
      $error("line size above maximum");                                // R3
   end
   if ((LINE_BYTES & (LINE_BYTES - 1)) != 0) begin : g_pow2
      $error("line size not a power of two");                           // R1
   end

   // Domain check; some types accept non-shareable too
   function automatic logic dom_ok(input logic [1:0] dom, input logic nonsh_ok);
      dom_ok = (dom == DOM_INNER) || (dom == DOM_OUTER) ||
               (nonsh_ok && dom == DOM_NONSH);                          // R10 R11
   endfunction : dom_ok

   // Normal access and modifiable attribute
   function automatic logic attr_ok(input logic [1:0] bar, input logic [3:0] cache);
      attr_ok = !bar[0] && cache[CACHE_MOD_BIT];                        // R12
   endfunction : attr_ok

   logic ar_shape_bad;
   logic aw_shape_bad;

   // Read burst shape
   line_shape_chk #(
      .BUS_BYTES  (BUS_BYTES),
      .LINE_BYTES (LINE_BYTES),
      .AW         (AW)
   ) u_ar_shape (
      .addr_i  (araddr_i),
      .len_i   (arlen_i),
      .size_i  (arsize_i),
      .burst_i (arburst_i),
      .bad_o   (ar_shape_bad)
   );

   // Write burst shape
   line_shape_chk #(
      .BUS_BYTES  (BUS_BYTES),
      .LINE_BYTES (LINE_BYTES),
      .AW         (AW)
   ) u_aw_shape (
      .addr_i  (awaddr_i),
      .len_i   (awlen_i),
      .size_i  (awsize_i),
      .burst_i (awburst_i),
      .bad_o   (aw_shape_bad)
   );

   logic ar_line;
   logic ar_nonsh_ok;
   logic ar_lock_ok;
   logic next_ar_bad;

   // Read side classification; barriers and non-line types pass untouched
   always_comb begin
      ar_line     = 1'b0;
      ar_nonsh_ok = 1'b0;
      ar_lock_ok  = 1'b0;
      case (arsnoop_i)
         RD_SHARED, RD_CLEAN, RD_CLN_UNQ: begin
            ar_line    = 1'b1;
            ar_lock_ok = 1'b1;                                          // R14
         end
         RD_NSD, RD_UNIQUE, RD_MK_UNQ: begin
            ar_line = 1'b1;                                             // R4
         end
         RD_CLN_SH, RD_CLN_INV, RD_MK_INV: begin
            ar_line     = 1'b1;
            ar_nonsh_ok = 1'b1;                                         // R11
         end
         default: ar_line = 1'b0;
      endcase
      // Snoop zero with no barrier is not line-sized
      if (arbar_i[0] || arsnoop_i == RD_ONCE_OR_NOSNOOP) begin
         ar_line = 1'b0;
      end
      // Protection and qos deliberately not examined
      next_ar_bad = ar_line && (ar_shape_bad ||
                    !dom_ok(ardomain_i, ar_nonsh_ok) ||
                    !attr_ok(arbar_i, arcache_i) ||
                    (arlock_i && !ar_lock_ok));                         // R13 R15
   end

   logic aw_line;
   logic aw_nonsh_ok;
   logic aw_full_strb;
   logic aw_has_data;
   logic next_aw_bad;

   // Write side classification
   always_comb begin
      aw_line      = 1'b0;
      aw_nonsh_ok  = 1'b0;
      aw_full_strb = 1'b0;
      aw_has_data  = 1'b1;
      case (awsnoop_i)
         WR_LINE_UNQ: begin
            aw_line      = 1'b1;
            aw_full_strb = 1'b1;
         end
         WR_EVICT_NODATA: begin
            aw_line     = 1'b1;
            aw_has_data = 1'b0;                                         // R17
         end
         WR_EVICT_DATA: begin
            aw_line      = 1'b1;
            aw_nonsh_ok  = 1'b1;
            aw_full_strb = 1'b1;
         end
         default: aw_line = 1'b0;
      endcase
      if (awbar_i[0]) begin
         aw_line      = 1'b0;
         aw_full_strb = 1'b0;
      end
      // All write line types forbid exclusive access
      next_aw_bad = aw_line && (aw_shape_bad ||
                    !dom_ok(awdomain_i, aw_nonsh_ok) ||
                    !attr_ok(awbar_i, awcache_i) ||
                    awlock_i);                                          // R13
   end

   logic ar_hs;
   logic aw_hs;
   logic w_hs;

   assign ar_hs = arvalid_i && arready_i;
   assign aw_hs = awvalid_i && awready_i;
   assign w_hs  = wvalid_i && wready_i;

   // Read violation flag, one cycle per offending handshake
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ar_violation_o <= 1'b0;
      end else begin
         ar_violation_o <= ar_hs && next_ar_bad;                        // R18
      end
   end

   // Write address violation flag
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         aw_violation_o <= 1'b0;
      end else begin
         aw_violation_o <= aw_hs && next_aw_bad;                        // R18
      end
   end

   // Strobe-check queue: one full-strobe flag per accepted write with data, ahead of its data.
   // Writes are assumed in order, data never ahead of its address.
   // Dataless evicts stay out, else every later burst pairs with a stale slot.
   localparam int QD = 16;
   localparam int QW = $clog2(QD);
   logic [QD-1:0]         strb_q;
   logic [$clog2(QD):0]   q_cnt;
   logic                  q_push;
   logic                  q_pop;
   logic                  head_full;

   assign q_push    = aw_hs && aw_has_data && (q_cnt != ($clog2(QD)+1)'(QD)); // R17
   assign q_pop     = w_hs && wlast_i && (q_cnt != '0);
   assign head_full = (q_cnt != '0) && strb_q[0];

   // Shift register of per-burst full-strobe demands
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         strb_q <= '0;
         q_cnt  <= '0;
      end else begin
         if (q_pop && q_push) begin
            strb_q        <= strb_q >> 1;
            strb_q[QW'(q_cnt - 1'b1)] <= aw_full_strb;
         end else if (q_pop) begin
            strb_q <= strb_q >> 1;
            q_cnt  <= q_cnt - 1'b1;
         end else if (q_push) begin
            strb_q[q_cnt[$clog2(QD)-1:0]] <= aw_full_strb;
            q_cnt <= q_cnt + 1'b1;
         end
      end
   end

   // Sparse strobe on a full-line write beat
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         w_violation_o <= 1'b0;
      end else begin
         w_violation_o <= w_hs && head_full && (wstrb_i != '1);         // R16
      end
   end
endmodule : line_txn_checker

/* File: line_chk_assertions.sv */
// Port-level checks for the line-size request checker
`timescale 1ns/1ps
module line_chk_assertions
   import line_chk_pkg::*;
#(
   parameter int BUS_BYTES = 16
) (
   input wire logic       core_clk_i,
   input wire logic       resetn_i,
   input wire logic       arvalid_i,
   input wire logic       arready_i,
   input wire logic [7:0] arlen_i,
   input wire logic [1:0] arburst_i,
   input wire logic       arlock_i,
   input wire logic [3:0] arsnoop_i,
   input wire logic [1:0] ardomain_i,
   input wire logic [1:0] arbar_i,
   input wire logic       awvalid_i,
   input wire logic       awready_i,
   input wire logic [7:0] awlen_i,
   input wire logic [2:0] awsize_i,
   input wire logic [3:0] awcache_i,
   input wire logic [2:0] awsnoop_i,
   input wire logic [1:0] awbar_i,
   input wire logic       wvalid_i,
   input wire logic       wready_i,
   input wire logic       ar_violation_o,
   input wire logic       aw_violation_o,
   input wire logic       w_violation_o
);
   localparam int SZ = $clog2(BUS_BYTES);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   // Accepted normal requests, and those of the line-sized kinds
   wire logic ar_hs = arvalid_i && arready_i && !arbar_i[0];
   wire logic ar_line = ar_hs && (arsnoop_i inside {4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'h9,
      4'hB, 4'hC, 4'hD});
   wire logic aw_line = awvalid_i && awready_i && !awbar_i[0] && (awsnoop_i inside {3'h1,
      3'h4, 3'h5});
   ar_cause_a: assert property (ar_violation_o |-> $past(arvalid_i && arready_i))
      else $error("read flag without handshake");
   aw_cause_a: assert property (aw_violation_o |-> $past(awvalid_i && awready_i))
      else $error("write flag without handshake");
   w_cause_a: assert property (w_violation_o |-> $past(wvalid_i && wready_i))
      else $error("data flag without beat");
   ar_len_a: assert property (ar_line && !(arlen_i inside {8'h00, 8'h01, 8'h03, 8'h07,
      8'h0F}) |=> ar_violation_o)
      else $error("odd beat count not flagged");
   ar_fixed_a: assert property (ar_line && arburst_i == BURST_FIXED |=> ar_violation_o)
      else $error("fixed burst not flagged");
   ar_domain_a: assert property (ar_hs && arsnoop_i inside {4'h1, 4'h2, 4'h3, 4'h7, 4'hB,
      4'hC} && ardomain_i == DOM_NONSH |=> ar_violation_o)
      else $error("non-shareable not flagged");
   ar_lock_a: assert property (ar_hs && arsnoop_i inside {4'h3, 4'h7, 4'hC, 4'h8, 4'h9,
      4'hD} && arlock_i |=> ar_violation_o)
      else $error("lock not flagged");
   barrier_quiet_a: assert property (arvalid_i && arready_i && arbar_i[0]
      |=> !ar_violation_o)
      else $error("barrier flagged");
   aw_size_a: assert property (aw_line && awlen_i != 8'h00 && awsize_i != SZ
      |=> aw_violation_o)
      else $error("narrow beats not flagged");
   aw_modif_a: assert property (aw_line && !awcache_i[CACHE_MOD_BIT] |=> aw_violation_o)
      else $error("non-modifiable not flagged");
endmodule : line_chk_assertions

/* File: ic_partner.sv */
// Interconnect model that accepts requests promptly or with stalls
`timescale 1ns/1ps
module ic_partner (
   input  wire logic core_clk_i,
   input  wire logic resetn_i,
   input  wire logic slow_i,
   output logic      arready_o,
   output logic      awready_o,
   output logic      wready_o
);
   logic [2:0] tick;
   // Free-running phase; stalls differ per channel, all three ready together when tick is 7
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) tick <= 3'h0;
      else tick <= tick + 3'h1;
   end
   assign arready_o = !slow_i || tick == 3'h7;
   assign awready_o = !slow_i || tick[1:0] == 2'h3;
   assign wready_o  = !slow_i || tick[0];
endmodule : ic_partner

/* File: ace_line_size_txn_checker_bench.sv */
// Self-checking bench for the line-size request checker
`timescale 1ns/1ps
module ace_line_size_txn_checker_bench;
   import line_chk_pkg::*;
   logic core_clk_i = 1'b0, resetn_i = 1'b0, slow = 1'b0, wlast_i = 1'b0;
   logic arvalid_i = 1'b0, awvalid_i = 1'b0, wvalid_i = 1'b0, arlock_i = 1'b0, awlock_i = 1'b0;
   logic arready_i, awready_i, wready_i, ar_violation_o, aw_violation_o, w_violation_o;
   logic [31:0] araddr_i = '0, awaddr_i = '0;
   logic [7:0]  arlen_i = '0, awlen_i = '0;
   logic [2:0]  arsize_i = '0, awsize_i = '0, arprot_i = '0, awprot_i = '0, awsnoop_i = '0;
   logic [1:0]  arburst_i = '0, awburst_i = '0, ardomain_i = '0, awdomain_i = '0;
   logic [1:0]  arbar_i = '0, awbar_i = '0;
   logic [3:0]  arcache_i = '0, awcache_i = '0, arqos_i = '0, awqos_i = '0, arsnoop_i = '0;
   logic [15:0] wstrb_i = '0;
   int          bad_count = 0, total_checks = 0, cycles = 0;
   line_txn_checker #(.BUS_BYTES(16), .LINE_BYTES(64), .AW(32)) u_dut (.*);
   ic_partner u_ic (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .slow_i(slow),
      .arready_o(arready_i), .awready_o(awready_i), .wready_o(wready_i));
   initial forever #4 core_clk_i = ~core_clk_i;
   // Hang guard, well above the roughly 150 cycles the tests need
   always @(posedge core_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         bad_count++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   task automatic check(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %0t: flag %b expected %b", $time, got, exp);
      end
   endtask : check
   // One read request, held until accepted; the flag is read in its pulse cycle
   task automatic rd(input logic [3:0] snp, input logic [1:0] dom, input logic [7:0] len,
         input logic [1:0] bst, input logic lk, input logic [1:0] bar, input logic [31:0] adr,
         input logic exp);
      @(posedge core_clk_i);
      {arsnoop_i, ardomain_i, arlen_i, arburst_i, arlock_i, arbar_i, araddr_i} <= {snp, dom,
         len, bst, lk, bar, adr};
      {arsize_i, arcache_i, arprot_i, arqos_i} <= {3'h4, 4'hF, snp[2:0], ~snp};
      arvalid_i <= 1'b1;
      do @(posedge core_clk_i); while (arready_i !== 1'b1);
      arvalid_i <= 1'b0;
      #1 check(ar_violation_o, exp);
   endtask : rd
   // Write address then four beats, none for a dataless evict; only the third beat takes the given strobes
   task automatic wr(input logic [2:0] snp, input logic [1:0] dom, input logic [2:0] sz,
         input logic [3:0] ca, input logic [15:0] stb, input logic eaw, input logic ew);
      @(posedge core_clk_i);
      {awsnoop_i, awdomain_i, awsize_i, awcache_i, awlen_i} <= {snp, dom, sz, ca, 8'h03};
      {awburst_i, awaddr_i, awprot_i, awqos_i} <= {BURST_INCR, 32'h80, sz, ca};
      awvalid_i <= 1'b1;
      do @(posedge core_clk_i); while (awready_i !== 1'b1);
      awvalid_i <= 1'b0;
      #1 check(aw_violation_o, eaw);
      for (int b = 0; b < 4 && snp != WR_EVICT_NODATA; b++) begin
         @(posedge core_clk_i);
         {wvalid_i, wlast_i, wstrb_i} <= {1'b1, b == 3, b == 2 ? stb : 16'hFFFF};
         do @(posedge core_clk_i); while (wready_i !== 1'b1);
         wvalid_i <= 1'b0;
         #1 check(w_violation_o, b == 2 && ew);
      end
   endtask : wr
   task automatic t_rd_legal();
      logic [3:0] codes [9] = '{4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'h9, 4'hB, 4'hC, 4'hD};
      foreach (codes[i]) rd(codes[i], codes[i] inside {4'h8, 4'h9, 4'hD} ? DOM_NONSH :
         DOM_OUTER, 8'h03, BURST_INCR, codes[i] inside {4'h1, 4'h2, 4'hB}, 2'h0, 32'h40,
         1'b0);
      $display("legal reads done");
   endtask : t_rd_legal
   task automatic t_rd_bad();
      slow <= 1'b1;
      rd(RD_UNIQUE, DOM_NONSH, 8'h03, BURST_INCR, 1'b0, 2'h0, 32'h40, 1'b1);
      rd(RD_NSD, DOM_INNER, 8'h03, BURST_INCR, 1'b1, 2'h0, 32'h40, 1'b1);
      rd(RD_CLEAN, DOM_INNER, 8'h03, BURST_FIXED, 1'b0, 2'h0, 32'h40, 1'b1);
      rd(RD_SHARED, DOM_INNER, 8'h02, BURST_INCR, 1'b0, 2'h0, 32'h40, 1'b1);
      rd(RD_SHARED, DOM_INNER, 8'h03, BURST_INCR, 1'b0, 2'h0, 32'h50, 1'b1);
      rd(RD_SHARED, DOM_INNER, 8'h03, BURST_WRAP, 1'b0, 2'h0, 32'h50, 1'b0);
      rd(RD_CLN_UNQ, DOM_INNER, 8'h00, BURST_INCR, 1'b0, 2'h0, 32'h40, 1'b1);
      rd(RD_ONCE_OR_NOSNOOP, DOM_NONSH, 8'h05, BURST_FIXED, 1'b1, 2'h1, 32'h3, 1'b0);
      slow <= 1'b0;
      $display("faulty reads done");
   endtask : t_rd_bad
   task automatic t_wr();
      wr(WR_LINE_UNQ, DOM_INNER, 3'h4, 4'hF, 16'hFFFF, 1'b0, 1'b0);
      wr(WR_LINE_UNQ, DOM_INNER, 3'h4, 4'hF, 16'hFF7F, 1'b0, 1'b1);
      wr(WR_EVICT_DATA, DOM_NONSH, 3'h4, 4'hF, 16'h0001, 1'b0, 1'b1);
      wr(WR_EVICT_NODATA, DOM_INNER, 3'h4, 4'h1, 16'hFFFF, 1'b1, 1'b0);
      // Sparse beat right after a dataless evict must still meet its own demand
      wr(WR_LINE_UNQ, DOM_OUTER, 3'h4, 4'hF, 16'hEFFF, 1'b0, 1'b1);
      wr(WR_LINE_UNQ, DOM_OUTER, 3'h3, 4'hF, 16'hFFFF, 1'b1, 1'b0);
      @(posedge core_clk_i);
      awlock_i <= 1'b1;
      wr(WR_EVICT_DATA, DOM_INNER, 3'h4, 4'hF, 16'hFFFF, 1'b1, 1'b0);
      @(posedge core_clk_i);
      awlock_i <= 1'b0;
      $display("writes done");
   endtask : t_wr
   // Reset for five cycles, then the scenarios in turn
   initial begin
      repeat (5) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      t_rd_legal();
      t_rd_bad();
      t_wr();
      end_of_test();
   end
endmodule : ace_line_size_txn_checker_bench
bind line_txn_checker line_chk_assertions #(.BUS_BYTES(BUS_BYTES)) u_chk (
   .core_clk_i(core_clk_i), .resetn_i(resetn_i),
   .arvalid_i(arvalid_i), .arready_i(arready_i), .arlen_i(arlen_i), .arburst_i(arburst_i),
   .arlock_i(arlock_i), .arsnoop_i(arsnoop_i), .ardomain_i(ardomain_i), .arbar_i(arbar_i),
   .awvalid_i(awvalid_i), .awready_i(awready_i), .awlen_i(awlen_i), .awsize_i(awsize_i),
   .awcache_i(awcache_i), .awsnoop_i(awsnoop_i), .awbar_i(awbar_i),
   .wvalid_i(wvalid_i), .wready_i(wready_i),
   .ar_violation_o(ar_violation_o), .aw_violation_o(aw_violation_o),
   .w_violation_o(w_violation_o)
);
